// File: verilog/vgtp_pkg.sv
// constants shared by the group multiplier and tail policy block
package vgtp_pkg;

  // register byte offsets on the bus
  localparam logic [7:0] VGTP_OFS_TYPE   = 8'h00;
  localparam logic [7:0] VGTP_OFS_REQ    = 8'h04;
  localparam logic [7:0] VGTP_OFS_COUNT  = 8'h08;
  localparam logic [7:0] VGTP_OFS_POLICY = 8'h0C;
  localparam logic [7:0] VGTP_OFS_STATUS = 8'h10;
  localparam int         VGTP_DEC_MSB    = 7;

  // type register layout
  localparam int VGTP_ILL_BIT   = 31;
  localparam int VGTP_RSV_MSB   = 30;
  localparam int VGTP_RSV_LSB   = 8;
  localparam int VGTP_MA_BIT    = 7;
  localparam int VGTP_TA_BIT    = 6;
  localparam int VGTP_SEW_MSB   = 5;
  localparam int VGTP_SEW_LSB   = 3;
  localparam int VGTP_GROUP_MULTIPLIER_MSB  = 2;
  localparam int VGTP_GROUP_MULTIPLIER_LSB  = 0;
  localparam logic [2:0] VGTP_GROUP_MULTIPLIER_RESERVED = 3'h4;
  localparam logic [31:0] VGTP_TYPE_RESET   = 32'h8000_0000;
  localparam logic [31:0] VGTP_TYPE_ILLEGAL = 32'h8000_0000;

  // element width code to log2 of bits
  localparam int VGTP_SEW_LOG_BASE = 3;
  localparam int VGTP_GROUP_MULTIPLIER_LOG_MAX = 3;

  // policy control bits
  localparam int VGTP_POL_HONOUR = 0;
  localparam int VGTP_POL_MERGE  = 1;
  localparam logic [1:0] VGTP_POLICY_RESET = 2'h1;

  // status bits
  localparam int VGTP_ST_ILLEGAL = 0;
  localparam int VGTP_ST_ALIGN   = 1;
  localparam int VGTP_ST_VILL    = 2;

  // bus codes
  localparam logic [1:0] VGTP_HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] VGTP_HTRANS_SEQ    = 2'h3;
  localparam logic [2:0] VGTP_HSIZE_WORD    = 3'h2;

endpackage

// File: verilog/vgtp_elem_if.sv
// element write-back request between the decoder and the merge unit
`timescale 1ns/1ps
interface vgtp_elem_if #(parameter int DATA_W = 64);
  logic              valid;
  logic              tail;
  logic              inactive;
  logic              dest_mask;
  logic              mask_load;
  logic              ta;
  logic              ma;
  logic              honour;
  logic              merge;
  logic [2:0]        sew_code;
  logic [DATA_W-1:0] old_data;
  logic [DATA_W-1:0] new_data;
  logic [DATA_W-1:0] full_data;
  logic              wb_valid;
  logic [DATA_W-1:0] wb_data;

  modport issue (output valid, tail, inactive, dest_mask, mask_load, ta, ma,
                 honour, merge, sew_code, old_data, new_data, full_data,
                 input wb_valid, wb_data);
  modport merge_unit (input valid, tail, inactive, dest_mask, mask_load, ta,
                      ma, honour, merge, sew_code, old_data, new_data,
                      full_data, output wb_valid, wb_data);
endinterface

// File: verilog/vgtp_elem_merge.sv
// destination element merge under tail and inactive policy
`timescale 1ns/1ps
module vgtp_elem_merge #(
  parameter int DATA_W = 64
) (
  // clock and reset
  input wire logic   hclk,
  input wire logic   hresetn,
  // element request
  vgtp_elem_if.merge_unit el
);

  wire logic              tail_agn;
  wire logic              inact_agn;
  wire logic              agnostic;
  wire logic              full_tail;
  wire logic [DATA_W-1:0] ones_fill;
  wire logic [DATA_W-1:0] next_data;

  function automatic logic [DATA_W-1:0] sew_ones(input logic [2:0] code);
    logic [DATA_W-1:0] m;
    m = '0;
    for (int i = 0; i < DATA_W; i++) begin
      if (i < (1 << (int'(code) + vgtp_pkg::VGTP_SEW_LOG_BASE)))
        m[i] = 1'b1;
    end
    return m;
  endfunction

  // mask tails are agnostic whatever ta says
  assign tail_agn  = el.dest_mask | el.ta; // RULE14 RULE13
  // merge mode keeps inactive undisturbed under ta+ma
  assign inact_agn = el.ma & ~(el.merge & el.ta); // RULE18 RULE13
  // in-order mode falls back to undisturbed everywhere
  assign agnostic  = el.honour &
                     ((el.tail & tail_agn) |
                      (~el.tail & el.inactive & inact_agn)); // RULE17
  // mask loads never expose memory beyond the length in the tail
  assign full_tail = el.dest_mask & el.tail & ~el.mask_load; // RULE19 RULE20
  assign ones_fill = sew_ones(el.sew_code); // RULE25 RULE16
  assign next_data = (~el.tail & ~el.inactive) ? el.new_data :
                     ~agnostic ? el.old_data : // RULE15
                     full_tail ? el.full_data : ones_fill;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      el.wb_valid <= 1'b0;
      el.wb_data  <= '0;
    end else begin
      el.wb_valid <= el.valid;
      if (el.valid)
        el.wb_data <= next_data;
    end
  end

endmodule

// File: verilog/vgtp_top.sv
// group multiplier decode, register alignment check and tail policy
//
// Summary of operation
// RULE1 - accept multipliers of one, two, four, eight
// RULE2 - widest 32: accept halves and quarters
// RULE3 - widest 64: accept half, quarter, eighth
// RULE4 - fractional: widths up to multiplier times widest
// RULE5 - multiplier below width ratio sets illegal flag
// RULE6 - signed three-bit multiplier field, 100 reserved
// RULE7 - max count = multiplier * length / width
// RULE8 - multiplier two: odd register is reserved
// RULE9 - multiplier four: register multiple of four
// RULE10 - multiplier eight: register multiple of eight
// RULE11 - mask operand always occupies one register
// RULE12 - widened operands use doubled multiplier
// RULE13 - two policy bits, undisturbed or agnostic
// RULE14 - mask destination tails always agnostic
// RULE15 - undisturbed elements keep previous values
// RULE16 - agnostic elements kept or filled with ones
// RULE17 - in-order mode treats all as undisturbed
// RULE18 - merge mode: ta+ma runs as ta+mu
// RULE19 - mask tails may take full-length result
// RULE20 - mask logic tails may take whole-register result
// RULE21 - flag bit 31, ma 7, ta 6, multiplier 2:0
// RULE22 - illegal flag raises exception on dependent instructions
// RULE23 - illegal flag forces all other bits zero
// RULE24 - reserved multiplier load sets illegal flag
// RULE25 - agnostic fill sets every bit of width
//
// Our own choices: the register addresses and the AHB-Lite register port.
`timescale 1ns/1ps
module vgtp_top #(
  parameter int REG_LEN_BITS = 128,
  parameter int WIDEST_ELEM  = 64,
  parameter int NARROW_ELEM  = 8
) (
  // clock and reset
  input  wire logic                   hclk,
  input  wire logic                   hresetn,
  // register bus
  input  wire logic                   hsel,
  input  wire logic [31:0]            haddr,
  input  wire logic [1:0]             htrans,
  input  wire logic                   hwrite,
  input  wire logic [2:0]             hsize,
  input  wire logic                   hready,
  input  wire logic [31:0]            hwdata,
  output wire logic                   hreadyout,
  output wire logic                   hresp,
  output      logic [31:0]            hrdata,
  // type load from the pipeline
  input  wire logic                   cfg_valid,
  input  wire logic [31:0]            cfg_value,
  // instruction issue check
  input  wire logic                   iss_valid,
  input  wire logic                   iss_type_dep,
  input  wire logic [4:0]             iss_vd,
  input  wire logic [4:0]             iss_vs1,
  input  wire logic [4:0]             iss_vs2,
  input  wire logic                   iss_vd_wide,
  input  wire logic                   iss_vs2_wide,
  input  wire logic                   iss_vd_mask,
  output      logic                   iss_done,
  output      logic                   iss_illegal,
  output      logic                   iss_misaligned,
  // element write-back
  input  wire logic                   el_valid,
  input  wire logic                   el_tail,
  input  wire logic                   el_inactive,
  input  wire logic                   el_dest_mask,
  input  wire logic                   el_mask_load,
  input  wire logic [WIDEST_ELEM-1:0] el_old,
  input  wire logic [WIDEST_ELEM-1:0] el_new,
  input  wire logic [WIDEST_ELEM-1:0] el_full,
  output wire logic                   wb_valid,
  output wire logic [WIDEST_ELEM-1:0] wb_data,
  // type view
  output      logic [31:0]            type_value,
  output      logic [31:0]            max_element_count
);

  localparam int WIDEST_LOG = $clog2(WIDEST_ELEM);
  localparam int NARROW_LOG = $clog2(NARROW_ELEM);
  localparam int LEN_LOG    = $clog2(REG_LEN_BITS);

  // widths the decode arithmetic can serve, refused at elaboration
  if (WIDEST_ELEM != 32 && WIDEST_ELEM != 64) begin
    $error("widest element width must be 32 or 64");
  end
  if (NARROW_ELEM != 8) begin
    $error("narrowest element width must be 8");
  end
  if (REG_LEN_BITS < WIDEST_ELEM || (1 << LEN_LOG) != REG_LEN_BITS) begin
    $error("register length must be a power of two >= widest width");
  end
  // count arithmetic shifts the length up by three inside an int
  if (REG_LEN_BITS > (1 << 28)) begin
    $error("register length too large for the count arithmetic");
  end

  // bus state
  logic        wr_pend;
  logic [7:0]  wr_addr;
  logic [31:0] req_value;
  logic [1:0]  policy;
  // type state
  logic [31:0] next_type;
  logic [31:0] next_count;
  logic        load_ok;

  // signed log2 of the multiplier from the field
  function automatic int group_multiplier_log(input logic [31:0] v);
    logic [2:0] f;
    f = v[vgtp_pkg::VGTP_GROUP_MULTIPLIER_MSB:vgtp_pkg::VGTP_GROUP_MULTIPLIER_LSB];
    return int'($signed(f)); // RULE6
  endfunction

  // log2 of the selected element width
  function automatic int sew_log(input logic [31:0] v);
    logic [2:0] f;
    f = v[vgtp_pkg::VGTP_SEW_MSB:vgtp_pkg::VGTP_SEW_LSB];
    return int'(f) + vgtp_pkg::VGTP_SEW_LOG_BASE;
  endfunction

  // whether a requested type is one this block supports
  function automatic logic type_ok(input logic [31:0] v);
    int   lm;
    int   sl;
    logic ok;
    lm = group_multiplier_log(v);
    sl = sew_log(v);
    ok = 1'b1;
    // reserved field code never adopted
    if (v[vgtp_pkg::VGTP_GROUP_MULTIPLIER_MSB:vgtp_pkg::VGTP_GROUP_MULTIPLIER_LSB] ==
        vgtp_pkg::VGTP_GROUP_MULTIPLIER_RESERVED)
      ok = 1'b0; // RULE24
    if (v[vgtp_pkg::VGTP_ILL_BIT:vgtp_pkg::VGTP_RSV_LSB] != '0)
      ok = 1'b0;
    if (sl > WIDEST_LOG || sl < NARROW_LOG)
      ok = 1'b0;
    // fractions down to narrowest over widest only
    if (lm < NARROW_LOG - WIDEST_LOG)
      ok = 1'b0; // RULE5 RULE2 RULE3
    // fractional: width at most multiplier times widest
    if (lm < 0 && sl > WIDEST_LOG + lm)
      ok = 1'b0; // RULE4
    return ok; // RULE1
  endfunction

  // elements per instruction for a legal type
  function automatic logic [31:0] count_of(input logic [31:0] v);
    int sh;
    sh = sew_log(v) + vgtp_pkg::VGTP_GROUP_MULTIPLIER_LOG_MAX - group_multiplier_log(v);
    return 32'((REG_LEN_BITS << vgtp_pkg::VGTP_GROUP_MULTIPLIER_LOG_MAX) >> sh); // RULE7
  endfunction

  // register number aligned to a group of 2**log registers
  function automatic logic grp_ok(input logic [4:0] r, input int lg);
    logic [4:0] m;
    m = 5'((1 << lg) - 1);
    if (lg > vgtp_pkg::VGTP_GROUP_MULTIPLIER_LOG_MAX)
      return 1'b0;
    if (lg <= 0)
      return 1'b1;
    return (r & m) == 5'h00; // RULE8 RULE9 RULE10
  endfunction

  // ---- bus decode
  wire logic        addr_phase;
  wire logic        word_ok;
  wire logic        bus_load;
  wire logic [31:0] load_value;
  wire logic        do_load;
  wire logic [31:0] rd_mux;
  wire logic [7:0]  dec_addr;
  wire logic        sel_type;
  wire logic        sel_req;
  wire logic        sel_count;
  wire logic        sel_policy;
  wire logic        sel_status;
  wire logic        wr_policy;
  wire logic        wr_start;
  wire logic        rd_start;
  wire logic [31:0] status_word;
  wire logic [31:0] next_rdata;

  assign addr_phase = hsel & hready &
                      (htrans == vgtp_pkg::VGTP_HTRANS_NONSEQ ||
                       htrans == vgtp_pkg::VGTP_HTRANS_SEQ);
  assign word_ok    = hsize == vgtp_pkg::VGTP_HSIZE_WORD;
  assign dec_addr   = haddr[vgtp_pkg::VGTP_DEC_MSB:0];
  assign hreadyout  = 1'b1;
  assign hresp      = 1'b0;
  assign bus_load   = wr_pend & (wr_addr == vgtp_pkg::VGTP_OFS_REQ);
  assign wr_policy  = wr_pend & (wr_addr == vgtp_pkg::VGTP_OFS_POLICY);

  // a read latches at its address phase, a write one cycle later
  assign wr_start   = addr_phase & hwrite & word_ok;
  assign rd_start   = addr_phase & ~hwrite;
  // pipeline load outranks a bus load in the same cycle
  assign do_load    = cfg_valid | bus_load;
  assign load_value = cfg_valid ? cfg_value : hwdata;

  assign sel_type   = dec_addr == vgtp_pkg::VGTP_OFS_TYPE;
  assign sel_req    = dec_addr == vgtp_pkg::VGTP_OFS_REQ;
  assign sel_count  = dec_addr == vgtp_pkg::VGTP_OFS_COUNT;
  assign sel_policy = dec_addr == vgtp_pkg::VGTP_OFS_POLICY;
  assign sel_status = dec_addr == vgtp_pkg::VGTP_OFS_STATUS;

  // status bits placed by name so the layout lives in one place
  assign status_word =
    (32'(iss_illegal) << vgtp_pkg::VGTP_ST_ILLEGAL) |
    (32'(iss_misaligned) << vgtp_pkg::VGTP_ST_ALIGN) |
    (32'(type_value[vgtp_pkg::VGTP_ILL_BIT]) << vgtp_pkg::VGTP_ST_VILL);

  // unmapped offsets read zero, writes dropped
  assign rd_mux =
    sel_type   ? type_value :
    sel_req    ? req_value :
    sel_count  ? max_element_count :
    sel_policy ? {30'h0000_0000, policy} :
    sel_status ? status_word :
    32'h0000_0000;
  assign next_rdata = word_ok ? rd_mux : 32'h0000_0000;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
      hrdata  <= 32'h0000_0000;
    end else begin
      wr_pend <= wr_start;
      wr_addr <= dec_addr;
      if (rd_start)
        hrdata <= next_rdata;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      req_value <= 32'h0000_0000;
      policy    <= vgtp_pkg::VGTP_POLICY_RESET;
    end else begin
      if (bus_load)
        req_value <= hwdata;
      if (wr_policy)
        policy <= hwdata[1:0];
    end
  end

  // ---- type register
  // decoded once so register and count never disagree
  assign load_ok    = type_ok(load_value);
  // illegal load keeps only the flag, all else zero
  assign next_type  = load_ok ?
    {1'b0, 23'h00_0000, load_value[vgtp_pkg::VGTP_MA_BIT:0]} :
    vgtp_pkg::VGTP_TYPE_ILLEGAL; // RULE23 RULE21
  assign next_count = load_ok ? count_of(load_value) :
                      32'h0000_0000;

  // ta and ma are stored even when in-order mode ignores them
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      type_value        <= vgtp_pkg::VGTP_TYPE_RESET;
      max_element_count <= 32'h0000_0000;
    end else if (do_load) begin
      type_value        <= next_type; // RULE17
      max_element_count <= next_count;
    end
  end

  // ---- issue check
  wire logic   vill;
  wire integer lm_cur;
  wire integer effective_multiplier_d;
  wire integer effective_multiplier_s1;
  wire integer effective_multiplier_s2;

  wire logic   vd_bad;
  wire logic   vs1_bad;
  wire logic   vs2_bad;
  wire logic   misaligned;
  wire logic   dep_trap;
  wire logic   next_illegal;
  wire logic   next_misaligned;

  assign vill    = type_value[vgtp_pkg::VGTP_ILL_BIT];
  assign lm_cur  = group_multiplier_log(type_value);
  // mask destination is a single register
  assign effective_multiplier_d  = iss_vd_mask ? 0 : lm_cur + int'(iss_vd_wide); // RULE11
  assign effective_multiplier_s1 = lm_cur;
  // double-width operands take twice the multiplier
  assign effective_multiplier_s2 = lm_cur + int'(iss_vs2_wide); // RULE12
  assign vd_bad     = ~grp_ok(iss_vd, effective_multiplier_d);
  assign vs1_bad    = ~grp_ok(iss_vs1, effective_multiplier_s1);
  assign vs2_bad    = ~grp_ok(iss_vs2, effective_multiplier_s2);
  assign misaligned = vd_bad | vs1_bad | vs2_bad;

  // a flagged type hides alignment, the trap already covers it
  assign dep_trap        = iss_type_dep & vill;
  assign next_illegal    = dep_trap | (iss_type_dep & misaligned); // RULE22
  assign next_misaligned = iss_type_dep & ~vill & misaligned;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      iss_done       <= 1'b0;
      iss_illegal    <= 1'b0;
      iss_misaligned <= 1'b0;
    end else begin
      iss_done <= iss_valid;
      if (iss_valid) begin
        iss_illegal    <= next_illegal;
        iss_misaligned <= next_misaligned;
      end
    end
  end

  // ---- element write-back
  vgtp_elem_if #(.DATA_W(WIDEST_ELEM)) el_bus ();

  assign el_bus.valid     = el_valid;
  assign el_bus.tail      = el_tail;
  assign el_bus.inactive  = el_inactive;
  assign el_bus.dest_mask = el_dest_mask;
  assign el_bus.mask_load = el_mask_load;
  assign el_bus.ta        = type_value[vgtp_pkg::VGTP_TA_BIT]; // RULE13
  assign el_bus.ma        = type_value[vgtp_pkg::VGTP_MA_BIT];
  assign el_bus.honour    = policy[vgtp_pkg::VGTP_POL_HONOUR];
  assign el_bus.merge     = policy[vgtp_pkg::VGTP_POL_MERGE];
  assign el_bus.sew_code  =
    type_value[vgtp_pkg::VGTP_SEW_MSB:vgtp_pkg::VGTP_SEW_LSB];
  assign el_bus.old_data  = el_old;
  assign el_bus.new_data  = el_new;
  assign el_bus.full_data = el_full;
  assign wb_valid         = el_bus.wb_valid;
  assign wb_data          = el_bus.wb_data;

  vgtp_elem_merge #(
    .DATA_W (WIDEST_ELEM)
  ) u_merge (
    .hclk    (hclk),
    .hresetn (hresetn),
    .el      (el_bus.merge_unit)
  );

endmodule

// File: testbench/vgtp_properties.sv
// assertions on the group multiplier and tail policy top ports
`timescale 1ns/1ps
module vgtp_checker #(
  parameter int WIDEST_ELEM = 64
) (
  // clock and reset
  input wire logic                   hclk,
  input wire logic                   hresetn,
  // type load and issue
  input wire logic                   cfg_valid,
  input wire logic [31:0]            cfg_value,
  input wire logic                   iss_valid,
  input wire logic                   iss_type_dep,
  input wire logic [4:0]             iss_vd,
  input wire logic                   iss_vd_mask,
  input wire logic                   iss_done,
  input wire logic                   iss_illegal,
  input wire logic                   iss_misaligned,
  // element write-back
  input wire logic                   el_valid,
  input wire logic                   el_tail,
  input wire logic                   el_dest_mask,
  input wire logic [WIDEST_ELEM-1:0] el_old,
  input wire logic                   wb_valid,
  input wire logic [WIDEST_ELEM-1:0] wb_data,
  input wire logic [31:0]            type_value,
  input wire logic [31:0]            max_element_count
);
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  a_type_clear: assert property (
    type_value[31] |-> type_value[30:0] == 31'h0 && max_element_count == 32'h0)
    else $error("type bits not clear under flag");
  a_resv_code: assert property (
    cfg_valid && cfg_value[2:0] == 3'h4 |=> type_value == 32'h8000_0000)
    else $error("reserved multiplier adopted");
  a_int_load: assert property (
    cfg_valid && cfg_value[31:8] == 24'h0 && !cfg_value[2]
      && cfg_value[5:3] <= 3'h2 |=> type_value == $past(cfg_value))
    else $error("legal type not stored");
  a_issue_done: assert property (
    iss_valid |=> iss_done)
    else $error("issue answer missing");
  a_flag_trap: assert property (
    iss_valid && iss_type_dep && type_value[31] |=> iss_illegal)
    else $error("flag did not trap");
  a_free_issue: assert property (
    iss_valid && !iss_type_dep |=> !iss_illegal)
    else $error("independent issue trapped");
  a_pair_odd: assert property (
    iss_valid && iss_type_dep && !type_value[31]
      && type_value[2:0] == 3'h1 && iss_vd[0]
      && !iss_vd_mask |=> iss_misaligned)
    else $error("odd pair register passed");
  a_oct_align: assert property (
    iss_valid && iss_type_dep && !type_value[31] && type_value[2:0] == 3'h3
      && iss_vd[2:0] != 3'h0 && !iss_vd_mask |=> iss_misaligned)
    else $error("unaligned eight group passed");
  a_tail_keep: assert property (
    el_valid && el_tail && !el_dest_mask && !type_value[6]
      |=> wb_valid && wb_data == $past(el_old))
    else $error("undisturbed tail changed");
endmodule

bind vgtp_top vgtp_checker #(.WIDEST_ELEM(WIDEST_ELEM)) i_vgtp_checker (
  .hclk(hclk), .hresetn(hresetn), .cfg_valid(cfg_valid),
  .cfg_value(cfg_value), .iss_valid(iss_valid), .iss_type_dep(iss_type_dep),
  .iss_vd(iss_vd), .iss_vd_mask(iss_vd_mask), .iss_done(iss_done),
  .iss_illegal(iss_illegal), .iss_misaligned(iss_misaligned),
  .el_valid(el_valid), .el_tail(el_tail), .el_dest_mask(el_dest_mask),
  .el_old(el_old), .wb_valid(wb_valid), .wb_data(wb_data),
  .type_value(type_value), .max_element_count(max_element_count));

// File: testbench/vgtp_pipe_model.sv
// issue pipeline model: type loads and issue checks
`timescale 1ns/1ps
module vgtp_pipe_model (
  // clock
  input  wire logic   hclk,
  // type load
  output logic        cfg_valid,
  output logic [31:0] cfg_value,
  // issue check
  output logic        iss_valid,
  output logic        iss_type_dep,
  output logic [4:0]  iss_vd,
  output logic [4:0]  iss_vs1,
  output logic [4:0]  iss_vs2,
  output logic        iss_vd_wide,
  output logic        iss_vs2_wide,
  output logic        iss_vd_mask
);
  initial begin
    {cfg_valid, cfg_value, iss_valid, iss_type_dep, iss_vd} = '0;
    {iss_vs1, iss_vs2, iss_vd_wide, iss_vs2_wide, iss_vd_mask} = '0;
  end

  task automatic set_type(input logic [31:0] v);
    @(posedge hclk);
    cfg_valid <= 1'b1;
    cfg_value <= v;
    @(posedge hclk);
    cfg_valid <= 1'b0;
    // idle word is scrambled so nothing leans on a stale value
    cfg_value <= ~v;
  endtask

  task automatic issue(input logic dep, input logic [4:0] vd,
                       input logic w, input logic m);
    @(posedge hclk);
    iss_valid <= 1'b1;
    iss_type_dep <= dep;
    iss_vd <= vd;
    iss_vs1 <= 5'h00;
    iss_vs2 <= 5'h00;
    iss_vd_wide <= w;
    iss_vs2_wide <= w;
    iss_vd_mask <= m;
    @(posedge hclk);
    iss_valid <= 1'b0;
    iss_vd <= ~vd;
  endtask
endmodule

// File: testbench/tb.sv
// self-checking bench for the group multiplier and tail policy block
`timescale 1ns/1ps
module tb;
  localparam int REG_LEN = 128;
  localparam int WIDE = 64;
  localparam logic [63:0] OLD  = 64'h1111_2222_3333_4444;
  localparam logic [63:0] NEW  = 64'h5555_6666_7777_8888;
  localparam logic [63:0] FULL = 64'h9999_AAAA_BBBB_CCCC;
  localparam logic [63:0] ONES = 64'h0000_0000_FFFF_FFFF;
  logic        hclk, hresetn, hsel, hwrite;
  logic [31:0] haddr, hwdata;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic        el_valid, el_tail, el_inactive, el_dest_mask, el_mask_load;
  wire         hreadyout, hresp, cfg_valid, iss_valid, iss_type_dep;
  wire         iss_vd_wide, iss_vs2_wide, iss_vd_mask, iss_done;
  wire         iss_illegal, iss_misaligned, wb_valid;
  wire  [31:0] hrdata, type_value, max_element_count, cfg_value;
  wire  [4:0]  iss_vd, iss_vs1, iss_vs2;
  wire  [63:0] wb_data;
  int          errors, cmp_count;

  `define CHK(got, exp) begin \
    cmp_count++; \
    if ((got) !== (exp)) begin \
      errors++; \
      $display("BAD at %0t got %h exp %h", $time, got, exp); \
    end \
  end

  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end

  vgtp_top #(.REG_LEN_BITS(REG_LEN), .WIDEST_ELEM(WIDE), .NARROW_ELEM(8))
    i_vgtp_top (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout),
    .hwdata(hwdata), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .cfg_valid(cfg_valid), .cfg_value(cfg_value), .iss_valid(iss_valid),
    .iss_type_dep(iss_type_dep), .iss_vd(iss_vd), .iss_vs1(iss_vs1),
    .iss_vs2(iss_vs2), .iss_vd_wide(iss_vd_wide),
    .iss_vs2_wide(iss_vs2_wide), .iss_vd_mask(iss_vd_mask),
    .iss_done(iss_done), .iss_illegal(iss_illegal),
    .iss_misaligned(iss_misaligned), .el_valid(el_valid), .el_tail(el_tail),
    .el_inactive(el_inactive), .el_dest_mask(el_dest_mask),
    .el_mask_load(el_mask_load), .el_old(OLD), .el_new(NEW), .el_full(FULL),
    .wb_valid(wb_valid), .wb_data(wb_data), .type_value(type_value),
    .max_element_count(max_element_count));

  vgtp_pipe_model i_vgtp_pipe_model (
    .hclk(hclk), .cfg_valid(cfg_valid), .cfg_value(cfg_value),
    .iss_valid(iss_valid), .iss_type_dep(iss_type_dep), .iss_vd(iss_vd),
    .iss_vs1(iss_vs1), .iss_vs2(iss_vs2), .iss_vd_wide(iss_vd_wide),
    .iss_vs2_wide(iss_vs2_wide), .iss_vd_mask(iss_vd_mask));

  task automatic print_verdict();
    $display("errors %0d compares %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  function automatic logic [63:0] exp_cfg(input logic [31:0] v);
    int lg;
    int w;
    lg = $signed(v[2:0]);
    w = 8 << v[5:3];
    if (v[31:8] != 24'h0 || v[2:0] == 3'h4 || v[5:3] > 3'h3 ||
        (lg < 0 && w > (WIDE >> -lg)))
      return {32'h8000_0000, 32'h0};
    return {v, 32'((REG_LEN << (lg + 3)) / w / 8)};
  endfunction

  // address phase, then data phase; each waits on hready
  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    int n;
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= vgtp_pkg::VGTP_HTRANS_NONSEQ;
    haddr <= {24'h0, a};
    hwrite <= wr;
    for (int p = 0; p < 2; p++) begin
      n = 0;
      do begin
        @(posedge hclk);
        n++;
      end while (hreadyout !== 1'b1 && n < 40);
      if (hreadyout !== 1'b1) begin
        errors++;
        print_verdict();
      end
      q = hrdata;
      htrans <= 2'h0;
      hwdata <= d;
    end
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    `CHK(q, e)
    `CHK(hresp, 1'b0)
  endtask

  task automatic load(input logic [31:0] v);
    logic [63:0] e;
    e = exp_cfg(v);
    i_vgtp_pipe_model.set_type(v);
    #1;
    `CHK({type_value, max_element_count}, e)
  endtask

  task automatic iss(input logic dep, input logic [4:0] vd,
                     input logic w, input logic m, input logic [1:0] e);
    i_vgtp_pipe_model.issue(dep, vd, w, m);
    #1;
    `CHK({iss_done, iss_illegal, iss_misaligned}, {1'b1, e})
  endtask

  // class bits: tail, inactive, mask destination, mask load
  task automatic elem(input logic [3:0] c, input logic [63:0] e);
    @(posedge hclk);
    el_valid <= 1'b1;
    {el_tail, el_inactive, el_dest_mask, el_mask_load} <= c;
    @(posedge hclk);
    el_valid <= 1'b0;
    #1;
    `CHK({wb_valid, wb_data}, {1'b1, e})
  endtask

  initial begin
    #400000;
    errors++;
    print_verdict();
  end

  initial begin
    logic [31:0] q;
    {hresetn, hsel, haddr, htrans, hwrite, hwdata} = '0;
    {el_valid, el_tail, el_inactive, el_dest_mask, el_mask_load} = '0;
    hsize = vgtp_pkg::VGTP_HSIZE_WORD;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    rd(vgtp_pkg::VGTP_OFS_TYPE, 32'h8000_0000);
    rd(vgtp_pkg::VGTP_OFS_POLICY, 32'h1);
    rd(vgtp_pkg::VGTP_OFS_STATUS, 32'h4);
    rd(8'h20, 32'h0);
    bus(1'b1, vgtp_pkg::VGTP_OFS_REQ, 32'h0000_00C1, q);
    bus(1'b1, vgtp_pkg::VGTP_OFS_TYPE, 32'h0, q);
    rd(vgtp_pkg::VGTP_OFS_TYPE, 32'h0000_00C1);
    rd(vgtp_pkg::VGTP_OFS_COUNT, 32'h20);
    for (int i = 0; i < 32; i++) begin
      load({24'h0, i[1:0], 1'b0, i[4:3], i[2:0]});
    end
    load(32'h0000_0020);
    load(32'h0000_0100);
    load(32'h0000_0001);
    iss(1'b1, 5'h03, 1'b0, 1'b0, 2'h3);
    iss(1'b1, 5'h02, 1'b1, 1'b0, 2'h3);
    iss(1'b1, 5'h04, 1'b1, 1'b0, 2'h0);
    load(32'h0000_0002);
    iss(1'b1, 5'h06, 1'b0, 1'b0, 2'h3);
    iss(1'b1, 5'h0C, 1'b0, 1'b0, 2'h0);
    load(32'h0000_0003);
    iss(1'b1, 5'h0C, 1'b0, 1'b0, 2'h3);
    iss(1'b1, 5'h10, 1'b0, 1'b0, 2'h0);
    iss(1'b1, 5'h03, 1'b0, 1'b1, 2'h0);
    load(32'h8000_0000);
    iss(1'b1, 5'h00, 1'b0, 1'b0, 2'h2);
    iss(1'b0, 5'h00, 1'b0, 1'b0, 2'h0);
    load(32'h0000_00D0);
    elem(4'h0, NEW);
    elem(4'h8, ONES);
    elem(4'h4, ONES);
    elem(4'hA, FULL);
    elem(4'hB, ONES);
    load(32'h0000_0010);
    elem(4'h8, OLD);
    elem(4'h4, OLD);
    elem(4'hA, FULL);
    load(32'h0000_00D0);
    bus(1'b1, vgtp_pkg::VGTP_OFS_POLICY, 32'h3, q);
    elem(4'h4, OLD);
    elem(4'h8, ONES);
    bus(1'b1, vgtp_pkg::VGTP_OFS_POLICY, 32'h0, q);
    rd(vgtp_pkg::VGTP_OFS_POLICY, 32'h0);
    elem(4'h8, OLD);
    elem(4'h4, OLD);
    rd(vgtp_pkg::VGTP_OFS_TYPE, 32'h0000_00D0);
    print_verdict();
  end
endmodule
